// File: rtl/sco_pkg.sv
// Constants and carrier types for the SPI option-control block.
// Assumes an AXI4-Lite master with 32-bit data and byte addressing.
package sco_pkg;
   // Bus geometry
   localparam int unsigned ADDR_W = 8;
   localparam int unsigned DATA_W = 32;
   // Register indices and byte addresses
   localparam logic [7:0] OPT_IDX = 8'h02;
   localparam logic [7:0] OPT_ADDR = OPT_IDX << 2;
   localparam logic [7:0] MODE_ADDR = 8'h10;
   localparam logic [7:0] STAT_ADDR = 8'h14;
   localparam logic [7:0] MASK_ADDR = 8'h18;
   localparam logic [7:0] PINS_ADDR = 8'h1c;
   // Option register layout
   localparam int unsigned OPT_MATCH_IE = 7;
   localparam int unsigned OPT_FAULT_EN = 4;
   localparam int unsigned OPT_DRIVE_EN = 3;
   localparam int unsigned OPT_HALT_WAIT = 1;
   localparam int unsigned OPT_SINGLE = 0;
   localparam logic [7:0] OPT_WR_MASK = 8'h9b;
   localparam logic [7:0] OPT_RESET = 8'h00;
   // Own registers: mode bits, status/mask bits
   localparam int unsigned MODE_MASTER = 0;
   localparam int unsigned MODE_SEL_OE = 1;
   localparam logic [1:0] MODE_RESET = 2'h0;
   localparam int unsigned STAT_FAULT = 0;
   localparam int unsigned STAT_HALT = 1;
   localparam logic [1:0] STAT_RESET = 2'h0;
   localparam logic [1:0] MASK_RESET = 2'h0;
   // Bus responses
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   // Synchroniser depth for pin inputs
   localparam int unsigned SYNC_STAGES = 2;

   typedef struct packed {
      logic match_irq_enable;
      logic unused6;
      logic rsvd5;
      logic fault_detect_enable;
      logic single_pin_drive_enable;
      logic rsvd2;
      logic halt_in_wait;
      logic single_wire_select;
   } sco_opt_t;

   typedef struct packed {
      logic sclk;
      logic ss;
      logic mosi;
      logic miso;
   } sco_pins_t;
endpackage

// File: rtl/sco_sync.sv
// Two-flop synchroniser for a bundle of pin inputs.
// Assumes the inputs are asynchronous to i_core_clk.
`timescale 1ns/100ps
module sco_sync #(
   parameter int unsigned W = 4
) (
   // Clock and reset
   input wire logic i_core_clk,
   input wire logic i_rst,
   // Pins in, synchronised out
   input wire logic [W-1:0] i_async,
   output logic [W-1:0] o_sync
);
   typedef struct packed {
      logic [W-1:0] meta;
      logic [W-1:0] stable;
   } sco_sync_st_t;

   sco_sync_st_t st_q;
   sco_sync_st_t st_d;

   // First stage is read only by the second
   always_comb begin
      st_d = st_q;
      st_d.meta = i_async;
      st_d.stable = st_q.meta;
   end

   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   assign o_sync = st_q.stable;
endmodule

// File: rtl/sco_top.sv
// SPI option-control register with pin steering, link sampling and
// interrupt logic, reached over AXI4-Lite.
// Assumes pins come from outside the clock domain; engine and wait
// inputs are synchronous to i_core_clk.
//
// The AXI4-Lite slave port is this design's own decision.
`timescale 1ns/100ps

// Functional notes
// RULE1: The option register sits at index 2, is read/write, 8 bits, and resets to zero.
// RULE2: Bit 6 is not implemented and always reads zero.
// RULE3: With match enable set, a set match flag raises the interrupt; with it clear it does not.
// RULE4: In slave mode the fault enable is ignored and the select pin is the select input.
// RULE5: As master with fault enable clear, the select pin is neither driven nor sensed.
// RULE6: As master with fault enable set, the select pin is fault input or select output by the output-enable bit.
// RULE7: With single-wire clear, the drive enable bit has no effect.
// RULE8: In single-wire mode the drive enable turns the shared pin into output, else input.
// RULE9: In single-wire mode the master uses its out pin and the slave its out pin as the only data pin.
// RULE10: With halt-in-wait set, SPI clocks stop in wait mode; with it clear they keep running.
// RULE11: Software must not write the reserved bits 5 and 2.
// RULE12: Single-wire clear uses separate data pins; set uses one shared pin, the other unused.
// RULE13: Reserved bits 5 and 2 read zero and writes to them do nothing.
module sco_top #(
   parameter int unsigned ADDR_W = sco_pkg::ADDR_W
) (
   // Clock and reset
   input wire logic i_core_clk,
   input wire logic i_rst,
   // AXI4-Lite write address and data
   input wire logic i_awvalid,
   output logic o_awready,
   input wire logic [ADDR_W-1:0] i_awaddr,
   input wire logic i_wvalid,
   output logic o_wready,
   input wire logic [31:0] i_wdata,
   input wire logic [3:0] i_wstrb,
   // AXI4-Lite write response
   output logic o_bvalid,
   input wire logic i_bready,
   output logic [1:0] o_bresp,
   // AXI4-Lite read
   input wire logic i_arvalid,
   output logic o_arready,
   input wire logic [ADDR_W-1:0] i_araddr,
   output logic o_rvalid,
   input wire logic i_rready,
   output logic [31:0] o_rdata,
   output logic [1:0] o_rresp,
   // Engine and system side
   input wire logic i_rx_match_flag,
   input wire logic i_wait_mode,
   input wire logic i_xfer_active,
   input wire logic i_tx_bit,
   output logic o_rx_bit,
   output logic o_slave_selected,
   output logic o_ss_released,
   output logic o_clk_run,
   output logic o_link_edge,
   output logic o_irq,
   // Serial pins
   input wire logic i_sclk,
   input wire logic i_ss_n,
   output logic o_ss_n,
   output logic o_ss_oe,
   input wire logic i_mosi,
   output logic o_mosi,
   output logic o_mosi_oe,
   input wire logic i_miso,
   output logic o_miso,
   output logic o_miso_oe
);
   typedef struct packed {
      logic aw_held;
      logic [ADDR_W-1:0] aw_addr;
      logic w_held;
      logic [7:0] w_data;
      logic w_lane0;
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
      sco_pkg::sco_opt_t opt;
      logic [1:0] mode;
      logic [1:0] status;
      logic [1:0] mask;
      logic sclk_prev;
      logic halted_prev;
      logic irq;
      logic rx_bit;
      logic slave_selected;
      logic ss_released;
      logic clk_run;
      logic link_edge;
      logic ss_n;
      logic ss_oe;
      logic mosi;
      logic mosi_oe;
      logic miso;
      logic miso_oe;
   } sco_state_t;

   sco_state_t st_q;
   sco_state_t st_d;
   sco_pkg::sco_pins_t pins_raw;
   sco_pkg::sco_pins_t pins;
   // Every pin passes two flops; select rides active high so reset reads idle
   assign pins_raw = '{sclk: i_sclk, ss: !i_ss_n, mosi: i_mosi, miso: i_miso};
   sco_sync #(
      .W($bits(sco_pkg::sco_pins_t))
   ) u_sync (
      .i_core_clk(i_core_clk),
      .i_rst(i_rst),
      .i_async(pins_raw),
      .o_sync(pins)
   );

   // Read data for one address; unmapped gives an error
   function automatic logic [33:0] read_word(input sco_state_t s,
                                             input logic [ADDR_W-1:0] a);
      logic [7:0] o;
      o = s.opt;
      o[6] = 1'b0; // [RULE2]
      o[5] = 1'b0; // [RULE13]
      o[2] = 1'b0; // [RULE13]
      unique case (8'(a))
         sco_pkg::OPT_ADDR: read_word = {sco_pkg::RESP_OKAY, 24'h0, o}; // [RULE1]
         sco_pkg::MODE_ADDR: read_word = {sco_pkg::RESP_OKAY, 30'h0, s.mode};
         sco_pkg::STAT_ADDR: read_word = {sco_pkg::RESP_OKAY, 30'h0, s.status};
         sco_pkg::MASK_ADDR: read_word = {sco_pkg::RESP_OKAY, 30'h0, s.mask};
         sco_pkg::PINS_ADDR: read_word = {sco_pkg::RESP_OKAY, 24'h0, 1'b0, s.clk_run,
                                          s.ss_released, s.slave_selected,
                                          s.ss_oe, s.mosi_oe, s.miso_oe, s.irq};
         default: read_word = {sco_pkg::RESP_SLVERR, 32'h0};
      endcase
   endfunction

   // Whole next state in one place
   always_comb begin
      logic do_write;
      logic [7:0] wa;
      logic master;
      logic sel_oe;
      logic fault_in;
      logic halted;
      logic [1:0] stat_set;
      logic [33:0] rd;
      do_write = 1'b0;
      wa = 8'h0;
      master = 1'b0;
      sel_oe = 1'b0;
      fault_in = 1'b0;
      halted = 1'b0;
      stat_set = 2'h0;
      rd = 34'h0;
      st_d = st_q;
      // Write channels taken independently, in either order
      if (i_awvalid && st_q.awready) begin
         st_d.aw_held = 1'b1;
         st_d.aw_addr = i_awaddr;
      end
      if (i_wvalid && st_q.wready) begin
         st_d.w_held = 1'b1;
         st_d.w_data = i_wdata[7:0];
         st_d.w_lane0 = i_wstrb[0];
      end
      if (st_q.bvalid && i_bready) begin
         st_d.bvalid = 1'b0;
      end
      do_write = st_q.aw_held && st_q.w_held && !st_q.bvalid;
      wa = 8'(st_q.aw_addr);
      if (do_write) begin
         st_d.aw_held = 1'b0;
         st_d.w_held = 1'b0;
         st_d.bvalid = 1'b1;
         st_d.bresp = sco_pkg::RESP_OKAY;
         unique case (wa)
            sco_pkg::OPT_ADDR: begin
               // Reserved and missing bits never store [RULE13]
               if (st_q.w_lane0) begin
                  st_d.opt = st_q.w_data & sco_pkg::OPT_WR_MASK; // [RULE1] [RULE2]
               end
            end
            sco_pkg::MODE_ADDR: begin
               if (st_q.w_lane0) begin
                  st_d.mode = st_q.w_data[1:0];
               end
            end
            sco_pkg::STAT_ADDR: begin
               if (st_q.w_lane0) begin
                  st_d.status = st_q.status & ~st_q.w_data[1:0];
               end
            end
            sco_pkg::MASK_ADDR: begin
               if (st_q.w_lane0) begin
                  st_d.mask = st_q.w_data[1:0];
               end
            end
            sco_pkg::PINS_ADDR: begin
               st_d.bresp = sco_pkg::RESP_OKAY;
            end
            default: st_d.bresp = sco_pkg::RESP_SLVERR;
         endcase
      end
      // Readies are registered; only one write in flight
      st_d.awready = !st_d.aw_held && !st_d.bvalid;
      st_d.wready = !st_d.w_held && !st_d.bvalid;
      // Read: answer on the same edge that takes the address
      if (st_q.rvalid && i_rready) begin
         st_d.rvalid = 1'b0;
      end
      if (i_arvalid && st_q.arready) begin
         rd = read_word(st_q, i_araddr);
         st_d.rvalid = 1'b1;
         st_d.rdata = rd[31:0];
         st_d.rresp = rd[33:32];
      end
      st_d.arready = !st_d.rvalid && !(i_arvalid && st_q.arready);
      // Clock gating in wait mode [RULE10]
      halted = st_q.opt.halt_in_wait && i_wait_mode;
      st_d.clk_run = !halted;
      st_d.halted_prev = halted;
      // Link edges only pass while clocks run [RULE10]
      st_d.sclk_prev = pins.sclk;
      st_d.link_edge = (pins.sclk != st_q.sclk_prev) && !halted;
      // Select pin steering
      master = st_q.mode[sco_pkg::MODE_MASTER];
      sel_oe = st_q.mode[sco_pkg::MODE_SEL_OE];
      st_d.ss_n = 1'b1;
      st_d.ss_oe = 1'b0;
      st_d.ss_released = 1'b0;
      st_d.slave_selected = 1'b0;
      if (!master) begin
         // Fault enable plays no part here [RULE4]
         st_d.slave_selected = pins.ss;
      end else if (!st_q.opt.fault_detect_enable) begin
         st_d.ss_released = 1'b1; // [RULE5]
      end else if (sel_oe) begin
         st_d.ss_oe = 1'b1; // [RULE6]
         st_d.ss_n = !i_xfer_active;
      end else begin
         fault_in = pins.ss; // [RULE6]
      end
      // Data pin steering
      st_d.mosi = i_tx_bit;
      st_d.miso = i_tx_bit;
      st_d.mosi_oe = 1'b0;
      st_d.miso_oe = 1'b0;
      if (!st_q.opt.single_wire_select) begin
         // Separate pins; drive enable ignored [RULE7] [RULE12]
         if (master) begin
            st_d.mosi_oe = 1'b1;
            st_d.rx_bit = pins.miso;
         end else begin
            st_d.miso_oe = pins.ss;
            st_d.rx_bit = pins.mosi;
         end
      end else if (master) begin
         // Shared pin is the master out pin [RULE9] [RULE12]
         st_d.mosi_oe = st_q.opt.single_pin_drive_enable; // [RULE8]
         st_d.rx_bit = pins.mosi;
      end else begin
         // Shared pin is the slave out pin [RULE9] [RULE12]
         st_d.miso_oe = st_q.opt.single_pin_drive_enable; // [RULE8]
         st_d.rx_bit = pins.miso;
      end
      // Sticky events; a set wins over a clear in the same cycle
      stat_set[sco_pkg::STAT_FAULT] = fault_in;
      stat_set[sco_pkg::STAT_HALT] = halted && !st_q.halted_prev;
      st_d.status = st_d.status | stat_set;
      // Match flag reaches the interrupt only through its enable [RULE3]
      st_d.irq = (st_q.opt.match_irq_enable && i_rx_match_flag) ||
                 (|(st_q.status & st_q.mask));
   end

   // One register stage for all state
   always_ff @(posedge i_core_clk or posedge i_rst) begin
      if (i_rst) begin
         st_q <= '0;
         st_q.opt <= sco_pkg::OPT_RESET; // [RULE1]
         st_q.mode <= sco_pkg::MODE_RESET;
         st_q.status <= sco_pkg::STAT_RESET;
         st_q.mask <= sco_pkg::MASK_RESET;
         st_q.awready <= 1'b1;
         st_q.wready <= 1'b1;
         st_q.arready <= 1'b1;
         st_q.ss_n <= 1'b1;
         st_q.clk_run <= 1'b1;
      end else begin
         st_q <= st_d;
      end
   end

   // Outputs straight from flops
   assign o_awready = st_q.awready;
   assign o_wready = st_q.wready;
   assign o_bvalid = st_q.bvalid;
   assign o_bresp = st_q.bresp;
   assign o_arready = st_q.arready;
   assign o_rvalid = st_q.rvalid;
   assign o_rdata = st_q.rdata;
   assign o_rresp = st_q.rresp;
   assign o_rx_bit = st_q.rx_bit;
   assign o_slave_selected = st_q.slave_selected;
   assign o_ss_released = st_q.ss_released;
   assign o_clk_run = st_q.clk_run;
   assign o_link_edge = st_q.link_edge;
   assign o_irq = st_q.irq;
   assign o_ss_n = st_q.ss_n;
   assign o_ss_oe = st_q.ss_oe;
   assign o_mosi = st_q.mosi;
   assign o_mosi_oe = st_q.mosi_oe;
   assign o_miso = st_q.miso;
   assign o_miso_oe = st_q.miso_oe;

   // Shared sequences
   sequence s_master_fault_off;
      st_q.mode[sco_pkg::MODE_MASTER] && !st_q.opt.fault_detect_enable;
   endsequence

   sequence s_single_master;
      st_q.opt.single_wire_select && st_q.mode[sco_pkg::MODE_MASTER];
   endsequence
   a_opt_bit6_zero: assert property ( // [RULE2]
      @(posedge i_core_clk) disable iff (i_rst)
      st_q.opt[6] == 1'b0 && st_q.opt[5] == 1'b0 && st_q.opt[2] == 1'b0)
      else $error("option reserved bit stored");
   a_match_irq: assert property ( // [RULE3]
      @(posedge i_core_clk) disable iff (i_rst)
      (st_q.opt.match_irq_enable && i_rx_match_flag) |=> o_irq)
      else $error("match did not raise irq");
   a_match_masked: assert property ( // [RULE3]
      @(posedge i_core_clk) disable iff (i_rst)
      (!st_q.opt.match_irq_enable && !(|(st_q.status & st_q.mask))) |=> !o_irq)
      else $error("irq without cause");
   a_slave_ss_in: assert property ( // [RULE4]
      @(posedge i_core_clk) disable iff (i_rst)
      !st_q.mode[sco_pkg::MODE_MASTER] |=> (!o_ss_oe && o_slave_selected == $past(pins.ss)))
      else $error("slave select misused");
   a_ss_release: assert property ( // [RULE5]
      @(posedge i_core_clk) disable iff (i_rst)
      s_master_fault_off |=> (o_ss_released && !o_ss_oe &&
                              (!st_q.status[sco_pkg::STAT_FAULT] ||
                               $past(st_q.status[sco_pkg::STAT_FAULT]))))
      else $error("select pin not released");
   a_ss_output: assert property ( // [RULE6]
      @(posedge i_core_clk) disable iff (i_rst)
      (st_q.mode == 2'h3 && st_q.opt.fault_detect_enable) |=> o_ss_oe)
      else $error("select output not driven");
   a_fault_sense: assert property ( // [RULE6]
      @(posedge i_core_clk) disable iff (i_rst)
      (st_q.mode == 2'h1 && st_q.opt.fault_detect_enable && pins.ss)
      |=> st_q.status[sco_pkg::STAT_FAULT])
      else $error("mode fault missed");
   a_single_drive: assert property ( // [RULE8]
      @(posedge i_core_clk) disable iff (i_rst)
      s_single_master |=> (o_mosi_oe == $past(st_q.opt.single_pin_drive_enable) && !o_miso_oe))
      else $error("shared pin drive wrong");
   a_normal_master: assert property ( // [RULE7]
      @(posedge i_core_clk) disable iff (i_rst)
      (!st_q.opt.single_wire_select && st_q.mode[sco_pkg::MODE_MASTER]) |=> o_mosi_oe)
      else $error("out pin not driven");
   a_halt_wait: assert property ( // [RULE10]
      @(posedge i_core_clk) disable iff (i_rst)
      (st_q.opt.halt_in_wait && i_wait_mode) |=> (!o_clk_run && !o_link_edge))
      else $error("clocks not stopped");
endmodule

// File: verification/sco_partner.sv
// Far-side SPI device model: link clock, select line and both data lines.
// Assumes the bench resolves each shared pin from both parties' enables.
`timescale 1ns/100ps
module sco_partner (
   // Controls from the bench
   input wire logic i_frame,
   input wire logic i_select,
   input wire logic i_drive,
   input wire logic i_bit,
   // Pins towards the device
   output logic o_sclk,
   output logic o_ss_n,
   output logic o_mosi,
   output logic o_miso,
   output logic o_data_oe
);
   // Link clock toggles only inside frames and stands low between them
   initial begin
      o_sclk = 1'b0;
      #137;
      forever begin
         #400;
         o_sclk = i_frame ? ~o_sclk : 1'b0;
      end
   end
   // Select held low while the bench asks for it
   assign o_ss_n = ~i_select;
   // Opposite levels on the two lines show which one the device reads
   assign o_mosi = i_bit;
   assign o_miso = ~i_bit;
   assign o_data_oe = i_drive;
endmodule

// File: verification/testbench.sv
// Self-checking bench for the SPI option-control block over AXI4-Lite.
// Assumes sco_pkg, sco_top and sco_partner are compiled before it.
`timescale 1ns/100ps
module testbench;
   logic i_core_clk = 1'b0;
   logic i_rst = 1'b1;
   logic i_awvalid, o_awready, i_wvalid, o_wready, o_bvalid, i_bready, o_arready, i_arvalid;
   logic o_rvalid, i_rready, i_rx_match_flag, i_wait_mode, i_xfer_active, i_tx_bit, o_rx_bit;
   logic o_slave_selected, o_ss_released, o_clk_run, o_link_edge, o_irq, i_sclk, i_ss_n;
   logic o_ss_n, o_ss_oe, i_mosi, o_mosi, o_mosi_oe, i_miso, o_miso, o_miso_oe;
   logic [7:0] i_awaddr, i_araddr;
   logic [31:0] i_wdata, o_rdata, d;
   logic [3:0] i_wstrb;
   logic [1:0] o_bresp, o_rresp, r;
   logic p_frame, p_sel, p_drive, p_bit, p_ss_n, p_mosi, p_miso, p_oe;
   logic idle_q = 1'b0;
   int errors = 0;
   int n_compared = 0;
   int c;
   // Pin table: mode, option, select low, expected pin-state word
   logic [1:0] t_mode [10] = '{0, 0, 0, 0, 1, 3, 1, 1, 1, 0};
   logic [7:0] t_opt [10] = '{8'h00, 8'h10, 8'h01, 8'h08, 8'h00, 8'h10, 8'h08, 8'h19, 8'h11, 8'h09};
   logic t_sel [10] = '{0, 1, 1, 1, 1, 0, 0, 0, 0, 0};
   logic [31:0] t_exp [10] = '{'h40, 'h52, 'h50, 'h52, 'h64, 'h4c, 'h64, 'h44, 'h40, 'h42};

   always #50 i_core_clk = ~i_core_clk;
   // Undriven lines wander every cycle so a stale value never passes
   always @(posedge i_core_clk) idle_q <= ~idle_q;
   // Design enable wins, then the partner, else the wandering level
   assign i_ss_n = o_ss_oe ? o_ss_n : p_ss_n;
   assign i_mosi = o_mosi_oe ? o_mosi : (p_oe ? p_mosi : idle_q);
   assign i_miso = o_miso_oe ? o_miso : (p_oe ? p_miso : ~idle_q);

   sco_top u_sco_top (.i_core_clk, .i_rst, .i_awvalid, .o_awready, .i_awaddr, .i_wvalid,
      .o_wready, .i_wdata, .i_wstrb, .o_bvalid, .i_bready, .o_bresp, .i_arvalid, .o_arready,
      .i_araddr, .o_rvalid, .i_rready, .o_rdata, .o_rresp, .i_rx_match_flag, .i_wait_mode,
      .i_xfer_active, .i_tx_bit, .o_rx_bit, .o_slave_selected, .o_ss_released, .o_clk_run,
      .o_link_edge, .o_irq, .i_sclk, .i_ss_n, .o_ss_n, .o_ss_oe, .i_mosi, .o_mosi, .o_mosi_oe,
      .i_miso, .o_miso, .o_miso_oe);
   sco_partner u_sco_partner (.i_frame(p_frame), .i_select(p_sel), .i_drive(p_drive),
      .i_bit(p_bit), .o_sclk(i_sclk), .o_ss_n(p_ss_n), .o_mosi(p_mosi), .o_miso(p_miso),
      .o_data_oe(p_oe));

   task automatic complete_run();
      $display("Comparisons %0d, mismatches %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         errors++;
         $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   // Bus tasks hold each channel until taken; a stuck slave ends the run
   task automatic axi_wr(input logic [7:0] a, input logic [31:0] wd);
      int n;
      n = 0;
      @(posedge i_core_clk);
      {i_awvalid, i_wvalid, i_bready} <= 3'h7;
      i_awaddr <= a;
      i_wdata <= wd;
      i_wstrb <= 4'hf;
      do begin
         @(posedge i_core_clk);
         n++;
         if (o_awready) i_awvalid <= 1'b0;
         if (o_wready) i_wvalid <= 1'b0;
      end while (o_bvalid !== 1'b1 && n < 40);
      r = o_bresp;
      i_bready <= 1'b0;
      if (n >= 40) begin
         errors++;
         complete_run();
      end
   endtask
   task automatic axi_rd(input logic [7:0] a);
      int n;
      n = 0;
      @(posedge i_core_clk);
      {i_arvalid, i_rready} <= 2'h3;
      i_araddr <= a;
      do begin
         @(posedge i_core_clk);
         n++;
         if (o_arready) i_arvalid <= 1'b0;
      end while (o_rvalid !== 1'b1 && n < 40);
      d = o_rdata;
      r = o_rresp;
      i_rready <= 1'b0;
      if (n >= 40) begin
         errors++;
         complete_run();
      end
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
      axi_rd(a);
      check(d, exp);
      check({30'h0, r}, {30'h0, sco_pkg::RESP_OKAY});
   endtask
   // Option first, then mode; pins settle a few edges later
   task automatic cfg(input logic [1:0] m, input logic [7:0] o);
      axi_wr(sco_pkg::OPT_ADDR, {24'h0, o});
      axi_wr(sco_pkg::MODE_ADDR, {30'h0, m});
      repeat (5) @(posedge i_core_clk);
   endtask
   task automatic count_edges();
      c = 0;
      repeat (48) begin
         @(posedge i_core_clk);
         if (o_link_edge === 1'b1) c++;
      end
   endtask

   initial begin
      {i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready, i_rx_match_flag} = '0;
      {i_wait_mode, i_xfer_active, i_tx_bit, p_frame, p_sel, p_drive, p_bit} = '0;
      {i_awaddr, i_araddr, i_wdata, i_wstrb} = '0;
      repeat (3) @(posedge i_core_clk);
      i_rst <= 1'b0;
      repeat (4) @(posedge i_core_clk);
      rd_chk(sco_pkg::OPT_ADDR, 32'h0);
      rd_chk(sco_pkg::PINS_ADDR, 32'h40);
      axi_rd(8'h40);
      check({30'h0, r}, {30'h0, sco_pkg::RESP_SLVERR});
      check(d, 32'h0);
      axi_wr(8'h40, 32'h0);
      check({30'h0, r}, {30'h0, sco_pkg::RESP_SLVERR});
      // Reserved bits 5 and 2 stay written as zero
      axi_wr(sco_pkg::OPT_ADDR, 32'hdb);
      check({30'h0, r}, {30'h0, sco_pkg::RESP_OKAY});
      rd_chk(sco_pkg::OPT_ADDR, 32'h9b);
      $display("register test done");
      for (int k = 0; k < 10; k++) begin
         p_sel <= t_sel[k];
         cfg(t_mode[k], t_opt[k]);
         rd_chk(sco_pkg::PINS_ADDR, t_exp[k]);
      end
      rd_chk(sco_pkg::STAT_ADDR, 32'h0);
      cfg(2'h3, 8'h10);
      i_xfer_active <= 1'b1;
      repeat (3) @(posedge i_core_clk);
      check(o_ss_n, 1'b0);
      i_xfer_active <= 1'b0;
      $display("pin steering test done");
      // Partner drives both data lines with opposite levels
      p_drive <= 1'b1;
      p_bit <= 1'b1;
      cfg(2'h1, 8'h11);
      check(o_rx_bit, 1'b1);
      cfg(2'h1, 8'h00);
      check(o_rx_bit, 1'b0);
      p_drive <= 1'b0;
      cfg(2'h1, 8'h19);
      i_tx_bit <= 1'b1;
      repeat (3) @(posedge i_core_clk);
      check(o_mosi, 1'b1);
      check(o_miso, 1'b1);
      $display("data pin test done");
      // Mode fault: sensed select low raises the masked interrupt
      axi_wr(sco_pkg::MASK_ADDR, 32'h1);
      cfg(2'h1, 8'h10);
      p_sel <= 1'b1;
      repeat (6) @(posedge i_core_clk);
      check(o_irq, 1'b1);
      rd_chk(sco_pkg::STAT_ADDR, 32'h1);
      p_sel <= 1'b0;
      repeat (4) @(posedge i_core_clk);
      axi_wr(sco_pkg::STAT_ADDR, 32'h1);
      repeat (2) @(posedge i_core_clk);
      check(o_irq, 1'b0);
      axi_wr(sco_pkg::MASK_ADDR, 32'h0);
      cfg(2'h0, 8'h80);
      i_rx_match_flag <= 1'b1;
      repeat (3) @(posedge i_core_clk);
      check(o_irq, 1'b1);
      cfg(2'h0, 8'h00);
      check(o_irq, 1'b0);
      i_rx_match_flag <= 1'b0;
      $display("interrupt test done");
      // Link edges seen in wait mode unless halting is enabled
      p_frame <= 1'b1;
      i_wait_mode <= 1'b1;
      count_edges();
      check(c != 0, 1'b1);
      check(o_clk_run, 1'b1);
      axi_wr(sco_pkg::OPT_ADDR, 32'h02);
      repeat (3) @(posedge i_core_clk);
      check(o_clk_run, 1'b0);
      count_edges();
      check(c, 0);
      rd_chk(sco_pkg::STAT_ADDR, 32'h2);
      i_wait_mode <= 1'b0;
      p_frame <= 1'b0;
      repeat (3) @(posedge i_core_clk);
      check(o_clk_run, 1'b1);
      $display("halt and link test done");
      // Mid-run reset returns the option register to zero
      i_rst <= 1'b1;
      repeat (3) @(posedge i_core_clk);
      i_rst <= 1'b0;
      repeat (4) @(posedge i_core_clk);
      rd_chk(sco_pkg::OPT_ADDR, 32'h0);
      $display("reset test done");
      complete_run();
   end
endmodule
